// ---- dv/pps_host_model.sv ----
// Host processor and push-button model at the far side of the controller.
// Assumes the bench sets hold level and button state just after CLK_IN edges.
`default_nettype none

module pps_host_model (
    input  wire logic clk_in,
    input  wire logic hold_req_in,
    input  wire logic press_in,
    input  wire logic float_in,
    output logic      hold_out,
    output logic      button_n_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic toggle = 1'b0;

    initial hold_out = 1'b0;

    // Hold pin: high to switch on, kept high through warm reset, low for off
    always @(posedge clk_in) begin
        hold_out <= hold_req_in;
        toggle   <= ~toggle;
    end

    // Unconnected button floats, so it never settles; else pull-up
    assign button_n_out = float_in ? toggle : ~press_in;

endmodule : pps_host_model

`default_nettype wire

// ---- dv/pps_power_ctrl_test.sv ----
// Self-checking bench of the power-state controller over APB.
// Assumes a hold-mode controller and the host model on the far side.
`default_nettype none

module pps_power_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pps_pkg::*;

    logic              clk, rst, por_ok, low_ok, mon_ok, bus_det, warm;
    logic              hold_req, press, flt, hold, button_n;
    logic              psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [THR_W-1:0]  start_thr, low_thr;
    logic [RES_W-1:0]  res;
    logic [2:0]        state;
    logic              det_en, busy, int_n;
    int                miscompares = 0;
    int                samples_checked = 0;

    pps_power_ctrl u_dut (
        .CLK_IN(clk), .RST_IN(rst), .POR_OK_IN(por_ok), .LOW_OK_IN(low_ok),
        .MON_OK_IN(mon_ok), .BUS_DET_IN(bus_det), .HOLD_IN(hold),
        .BUTTON_N_IN(button_n), .WARM_RST_IN(warm), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .START_THR_OUT(start_thr),
        .LOW_THR_OUT(low_thr), .BUS_DET_EN_OUT(det_en),
        .RESOURCE_OUT(res), .STATE_OUT(state), .SEQ_BUSY_OUT(busy),
        .INT_N_OUT(int_n)
    );

    pps_host_model u_host (
        .clk_in(clk), .hold_req_in(hold_req), .press_in(press),
        .float_in(flt), .hold_out(hold), .button_n_out(button_n)
    );

    task automatic end_of_test;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Entered just after a rising edge; one edge passes after release
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        int i;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            miscompares++;
            end_of_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk

    task automatic wait_st(input logic [2:0] s, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge clk);
            if (state === s) break;
        end
        chk(32'(state), 32'(s));
        if (i == n) begin
            end_of_test();
        end
    endtask : wait_st

    // A sequence is at most four steps of STEP_CYC cycles
    task automatic wait_idle;
        int i;
        for (i = 0; i < 5 * STEP_CYC; i++) begin
            @(posedge clk);
            if (busy === 1'b0) break;
        end
        chk(32'(busy), 32'h0);
        if (i == 5 * STEP_CYC) begin
            end_of_test();
        end
    endtask : wait_idle

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        {rst, por_ok, low_ok, mon_ok, bus_det, warm} = 6'h20;
        {hold_req, press, flt, psel, penable, pwrite} = 6'h00;
        paddr = '0;
        pwdata = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        chk(32'(state), 32'(PPS_NOSUP));
        chk(32'(det_en), 32'h0);
        rdchk(OFS_VERSION, {24'h0, OTP_VERSION});
        rdchk(OFS_START, {20'h0, OTP_START_MV});
        rdchk(OFS_LOW, {20'h0, OTP_LOW_MV});
        chk(32'(low_thr), {20'h0, OTP_LOW_MV});
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        por_ok <= 1'b1;
        wait_st(PPS_BACKUP, 4);
        chk(32'(det_en), 32'h1);
        low_ok <= 1'b1;
        wait_st(PPS_OFF, 4);
        // Monitor high so only the missing hold request keeps it off
        flt <= 1'b1;
        mon_ok <= 1'b1;
        repeat (40) @(posedge clk);
        chk(32'(state), 32'(PPS_OFF));
        flt <= 1'b0;
        mon_ok <= 1'b0;
        hold_req <= 1'b1;
        repeat (20) @(posedge clk);
        chk(32'(state), 32'(PPS_OFF));
        mon_ok <= 1'b1;
        wait_st(PPS_ACTIVE, 8);
        chk(32'(busy), 32'h1);
        wait_idle();
        chk(32'(res), 32'hFF);
        rdchk(OFS_STATUS, 32'hE0 | 32'(PPS_ACTIVE));
        wr(OFS_RES, 32'hF0);
        rdchk(OFS_RES, 32'hF0);
        wr(OFS_START, 32'h123);
        chk(32'(start_thr), 32'h123);
        wr(OFS_EVENT, 32'h7);
        bus_det <= 1'b1;
        repeat (4) @(posedge clk);
        chk(32'(int_n), 32'h0);
        rdchk(OFS_EVENT, 32'h1);
        wr(OFS_MASK, 32'h1);
        chk(32'(int_n), 32'h1);
        bus_det <= 1'b0;
        wr(OFS_CTRL, 32'h1 << CMD_SLEEP);
        wait_st(PPS_SLEEP, 4);
        wait_idle();
        chk(32'(res), 32'h00);
        bus_det <= 1'b1;
        wait_st(PPS_ACTIVE, 6);
        wait_idle();
        chk(32'(res), 32'hF0);
        // Hold stays high across the warm reset
        warm <= 1'b1;
        @(posedge clk);
        warm <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(state), 32'(PPS_ACTIVE));
        chk(32'(start_thr), {20'h0, OTP_START_MV});
        rdchk(OFS_MASK, 32'h0);
        wait_idle();
        chk(32'(res), 32'hFF);
        chk(32'(state), 32'(PPS_ACTIVE));
        wr(OFS_CTRL, 32'h1 << CMD_WARM);
        chk(32'(res), 32'h00);
        wait_idle();
        wr(OFS_CTRL, 32'h1 << CMD_SLEEP);
        wait_st(PPS_SLEEP, 4);
        wait_idle();
        chk(32'(res), 32'h0F);
        wr(OFS_CTRL, 32'h1 << CMD_WAKE);
        wait_st(PPS_ACTIVE, 4);
        wait_idle();
        wr(OFS_CTRL, 32'h1 << CMD_SLEEP);
        wait_st(PPS_SLEEP, 4);
        wait_idle();
        press <= 1'b1;
        wait_st(PPS_ACTIVE, 8);
        press <= 1'b0;
        wait_idle();
        chk(32'(res), 32'hFF);
        wr(OFS_CTRL, 32'h1 << CMD_OFF);
        wait_st(PPS_OFF, 4);
        wait_idle();
        chk(32'(res), 32'h00);
        // Hold still high, so the controller comes straight back on
        wait_st(PPS_ACTIVE, 4);
        wait_idle();
        chk(32'(res), 32'hFF);
        hold_req <= 1'b0;
        wait_st(PPS_OFF, 8);
        wait_idle();
        chk(32'(res), 32'h00);
        bus_det <= 1'b0;
        repeat (3) @(posedge clk);
        bus_det <= 1'b1;
        wait_st(PPS_ACTIVE, 6);
        low_ok <= 1'b0;
        wait_st(PPS_BACKUP, 4);
        por_ok <= 1'b0;
        wait_st(PPS_NOSUP, 4);
        chk(32'(det_en), 32'h0);
        end_of_test();
    end

endmodule : pps_power_ctrl_test

`default_nettype wire

// ---- verilog/pps_pkg.sv ----
// Constants, state encoding and register map of the power-state controller.
// Assumes an APB master on the same clock and comparator levels from analog.
// Functional notes
// - Below power-on level, sit in no-supply state with everything off.
// - Main supply above power-on level moves no-supply to backup.
// - Main supply above low-supply threshold moves backup to off.
// - Supply below low threshold in active, sleep or off returns to backup.
// - Off to active is gated by the supply monitor comparator.
// - Start threshold defaults to the programmed 3.1 V.
// - Low-supply threshold defaults to the programmed 2.75 V.
// - After power-up software may rewrite the start threshold; it is applied. Code takes the write only in active or sleep.
// - Bus-supply detector runs whenever above power-on level.
// - Bus-supply detector crossing raises an interrupt event.
// - Bus-supply trigger wakes from sleep and switches on from off.
// - Hold input or button press switches on and starts start-up sequence.
// - In hold configuration a floating button gives no false switch-on.
// - In button configuration a falling button edge (a press) is the on request.
// - Warm reset restores defaults without passing through off; it is taken only in active with no sequence running.
// - Programmed configuration version is readable in a register.
// - Every transition between off, active and sleep runs a power sequence of resource writes.
// - Resource states stay writable by software after the sequence ends.
// - All events combine onto one interrupt line, active low.
`default_nettype none

package pps_pkg;

    typedef enum logic [2:0] {
        PPS_NOSUP  = 3'b000,
        PPS_BACKUP = 3'b001,
        PPS_OFF    = 3'b010,
        PPS_ACTIVE = 3'b011,
        PPS_SLEEP  = 3'b100
    } pps_state_t;

    localparam int ADDR_W = 8;
    localparam int THR_W  = 12;
    localparam int RES_W  = 8;
    localparam int EVT_W  = 3;

    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_START   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LOW     = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_RES     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EVENT   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_VERSION = 8'h1C;

    // Command bits of the control register, write-only pulses
    localparam int CMD_SLEEP = 0;
    localparam int CMD_WAKE  = 1;
    localparam int CMD_OFF   = 2;
    localparam int CMD_WARM  = 3;

    // Event bits
    localparam int EVT_BUS    = 0;
    localparam int EVT_BUTTON = 1;
    localparam int EVT_LOW    = 2;

    // Thresholds in millivolts: 3100 and 2750
    localparam logic [THR_W-1:0] OTP_START_MV = 12'hC1C;
    localparam logic [THR_W-1:0] OTP_LOW_MV   = 12'hABE;
    localparam logic [7:0]       OTP_VERSION  = 8'h5A;  // Arbitrary value

    localparam logic [RES_W-1:0] RES_RST  = 8'h00;
    localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
    localparam logic [RES_W-1:0] STEP_BITS = 8'h03;
    localparam logic [1:0] STEP_FIRST = 2'h0;
    localparam logic [1:0] STEP_LAST  = 2'h3;
    localparam logic [1:0] STEP_SLEEP = 2'h2;

    localparam int CLK_PERIOD_NS = 8;
    localparam int STEP_TIME_NS  = 1000;
    localparam int STEP_CYC =
        (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pps_pkg

`default_nettype wire

// ---- verilog/pps_power_ctrl.sv ----
// Power-state controller: state machine, sequencer and APB registers.
// Assumes comparator results and APB signals are synchronous to CLK_IN.
`default_nettype none

module pps_power_ctrl #(
    parameter logic [pps_pkg::THR_W-1:0] OTP_START = pps_pkg::OTP_START_MV,
    parameter logic [pps_pkg::THR_W-1:0] OTP_LOW   = pps_pkg::OTP_LOW_MV,
    parameter logic [7:0]                VERSION   = pps_pkg::OTP_VERSION,
    parameter bit                        HOLD_MODE = 1'b1
) (
    input  wire logic                          CLK_IN,
    input  wire logic                          RST_IN,
    input  wire logic                          POR_OK_IN,
    input  wire logic                          LOW_OK_IN,
    input  wire logic                          MON_OK_IN,
    input  wire logic                          BUS_DET_IN,
    input  wire logic                          HOLD_IN,
    input  wire logic                          BUTTON_N_IN,
    input  wire logic                          WARM_RST_IN,
    input  wire logic                          PSEL_IN,
    input  wire logic                          PENABLE_IN,
    input  wire logic                          PWRITE_IN,
    input  wire logic [pps_pkg::ADDR_W-1:0]    PADDR_IN,
    input  wire logic [31:0]                   PWDATA_IN,
    output logic      [31:0]                   PRDATA_OUT,
    output logic                               PREADY_OUT,
    output logic                               PSLVERR_OUT,
    output logic      [pps_pkg::THR_W-1:0]     START_THR_OUT,
    output logic      [pps_pkg::THR_W-1:0]     LOW_THR_OUT,
    output logic                               BUS_DET_EN_OUT,
    output logic      [pps_pkg::RES_W-1:0]     RESOURCE_OUT,
    output logic      [2:0]                    STATE_OUT,
    output logic                               SEQ_BUSY_OUT,
    output logic                               INT_N_OUT
);
    import pps_pkg::*;

    function automatic logic [RES_W-1:0] step_mask(input logic [1:0] idx);
        step_mask = STEP_BITS << {idx, 1'b0};
    endfunction : step_mask

    pps_state_t       state;
    pps_state_t       next_state;
    logic [1:0]       hold_sync;
    logic [1:0]       btn_sync;
    logic             btn_prev;
    logic             bus_prev;
    logic [THR_W-1:0] start_thr;
    logic [RES_W-1:0] resource;
    logic [EVT_W-1:0] event_flags;
    logic [EVT_W-1:0] event_mask;
    logic [31:0]      prdata;
    logic             seq_busy;
    logic             seq_up;
    logic [1:0]       seq_idx;
    logic [1:0]       seq_end;
    logic [7:0]       wait_cnt;
    logic             seq_go;
    logic             go_up;
    logic [1:0]       go_first;
    logic [1:0]       go_last;
    logic             warm_go;

    // Hold and button pins two flops each, only the second stage read; bus detector read raw and through one flop
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            hold_sync <= 2'h0;
            btn_sync  <= 2'h3;
            btn_prev  <= 1'b1;
            bus_prev  <= 1'b0;
        end else begin
            hold_sync <= {hold_sync[0], HOLD_IN};
            btn_sync  <= {btn_sync[0], BUTTON_N_IN};
            btn_prev  <= btn_sync[1];
            bus_prev  <= BUS_DET_IN;
        end
    end

    wire hold_s    = hold_sync[1];
    wire press_evt = btn_prev & ~btn_sync[1];
    wire powered   = state != PPS_NOSUP;
    wire bus_cross = powered & (BUS_DET_IN ^ bus_prev);
    wire bus_evt   = powered & BUS_DET_IN & ~bus_prev;
    wire low_loss  = POR_OK_IN & ~LOW_OK_IN &
                     (state == PPS_ACTIVE || state == PPS_SLEEP ||
                      state == PPS_OFF);

    // APB decode
    wire apb_wr   = PSEL_IN & PENABLE_IN & PWRITE_IN;
    wire apb_setup = PSEL_IN & ~PENABLE_IN;
    wire a_ctrl   = PADDR_IN == OFS_CTRL;
    wire a_status = PADDR_IN == OFS_STATUS;
    wire a_start  = PADDR_IN == OFS_START;
    wire a_low    = PADDR_IN == OFS_LOW;
    wire a_res    = PADDR_IN == OFS_RES;
    wire a_event  = PADDR_IN == OFS_EVENT;
    wire a_mask   = PADDR_IN == OFS_MASK;
    wire a_ver    = PADDR_IN == OFS_VERSION;
    wire mapped   = a_ctrl | a_status | a_start | a_low | a_res |
                    a_event | a_mask | a_ver;
    wire wr_ctrl  = apb_wr & a_ctrl;
    wire cmd_sleep = wr_ctrl & PWDATA_IN[CMD_SLEEP];
    wire cmd_wake  = wr_ctrl & PWDATA_IN[CMD_WAKE];
    wire cmd_off   = wr_ctrl & PWDATA_IN[CMD_OFF];
    wire cmd_warm  = wr_ctrl & PWDATA_IN[CMD_WARM];

    // Button is ignored for switch-on in hold configuration, but a press still wakes from sleep
    wire on_req   = (HOLD_MODE ? hold_s : press_evt) | bus_evt;
    wire off_req  = cmd_off | (HOLD_MODE & ~hold_s);
    wire wake_req = cmd_wake | bus_evt | press_evt;
    wire warm_req = cmd_warm | WARM_RST_IN;
    wire run_up   = state == PPS_ACTIVE || state == PPS_SLEEP;

    wire [31:0] status_word = {24'h0, MON_OK_IN, LOW_OK_IN, POR_OK_IN,
                               BUS_DET_IN, seq_busy, state};
    wire [31:0] rd_mux =
        a_status ? status_word :
        a_start  ? {20'h0, start_thr} :
        a_low    ? {20'h0, OTP_LOW} :
        a_res    ? {24'h0, resource} :
        a_event  ? {29'h0, event_flags} :
        a_mask   ? {29'h0, event_mask} :
        a_ver    ? {24'h0, VERSION} :
                   32'h0;

    always_comb begin
        next_state = state;
        seq_go     = 1'b0;
        go_up      = 1'b1;
        go_first   = STEP_FIRST;
        go_last    = STEP_LAST;
        warm_go    = 1'b0;
        if (!POR_OK_IN) begin
            next_state = PPS_NOSUP;
        end else begin
            case (state)
                PPS_NOSUP: begin
                    next_state = PPS_BACKUP;
                end
                PPS_BACKUP: begin
                    if (LOW_OK_IN) begin
                        next_state = PPS_OFF;
                    end
                end
                PPS_OFF: begin
                    if (!LOW_OK_IN) begin
                        next_state = PPS_BACKUP;
                    end else if (on_req && MON_OK_IN && !seq_busy) begin
                        next_state = PPS_ACTIVE;
                        seq_go     = 1'b1;
                    end
                end
                PPS_ACTIVE: begin
                    if (!LOW_OK_IN) begin
                        next_state = PPS_BACKUP;
                    end else if (!seq_busy) begin
                        if (off_req) begin
                            next_state = PPS_OFF;
                            seq_go     = 1'b1;
                            go_up      = 1'b0;
                            go_first   = STEP_LAST;
                            go_last    = STEP_FIRST;
                        end else if (warm_req) begin
                            seq_go  = 1'b1;
                            warm_go = 1'b1;
                        end else if (cmd_sleep) begin
                            next_state = PPS_SLEEP;
                            seq_go     = 1'b1;
                            go_up      = 1'b0;
                            go_first   = STEP_LAST;
                            go_last    = STEP_SLEEP;
                        end
                    end
                end
                PPS_SLEEP: begin
                    if (!LOW_OK_IN) begin
                        next_state = PPS_BACKUP;
                    end else if (!seq_busy) begin
                        if (off_req) begin
                            next_state = PPS_OFF;
                            seq_go     = 1'b1;
                            go_up      = 1'b0;
                            go_first   = STEP_LAST;
                            go_last    = STEP_FIRST;
                        end else if (wake_req) begin
                            next_state = PPS_ACTIVE;
                            seq_go     = 1'b1;
                            go_first   = STEP_SLEEP;
                        end
                    end
                end
                default: begin
                    next_state = PPS_NOSUP;
                end
            endcase
        end
    end

    wire supply_gone = next_state == PPS_NOSUP ||
                       next_state == PPS_BACKUP;
    wire step_now    = seq_busy && wait_cnt == 8'h00;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state <= PPS_NOSUP;
        end else begin
            state <= next_state;
        end
    end

    // Sequencer: one resource write per step, a fixed gap between steps
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            seq_busy <= 1'b0;
            seq_up   <= 1'b1;
            seq_idx  <= STEP_FIRST;
            seq_end  <= STEP_LAST;
            wait_cnt <= 8'h00;
        end else if (supply_gone) begin
            seq_busy <= 1'b0;
        end else if (seq_go) begin
            seq_busy <= 1'b1;
            seq_up   <= go_up;
            seq_idx  <= go_first;
            seq_end  <= go_last;
            wait_cnt <= 8'(STEP_CYC - 1);
        end else if (step_now) begin
            seq_busy <= seq_idx != seq_end;
            seq_idx  <= seq_up ? seq_idx + 2'h1 : seq_idx - 2'h1;
            wait_cnt <= 8'(STEP_CYC - 1);
        end else if (seq_busy) begin
            wait_cnt <= wait_cnt - 8'h01;
        end
    end

    // Supply loss wins, then sequence steps, then software writes
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            resource <= RES_RST;
        end else if (supply_gone || warm_go) begin
            resource <= RES_RST;
        end else if (step_now) begin
            resource <= seq_up ? resource | step_mask(seq_idx)
                               : resource & ~step_mask(seq_idx);
        end else if (apb_wr && a_res && !seq_busy) begin
            resource <= PWDATA_IN[RES_W-1:0];
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            start_thr <= OTP_START;
        end else if (warm_go || state == PPS_NOSUP) begin
            start_thr <= OTP_START;
        end else if (apb_wr && a_start && run_up) begin
            start_thr <= PWDATA_IN[THR_W-1:0];
        end
    end

    // Events: a set in the same cycle as a clear wins
    wire [EVT_W-1:0] evt_set = {low_loss, press_evt & powered, bus_cross};
    wire [EVT_W-1:0] evt_clr = (apb_wr && a_event) ?
                               PWDATA_IN[EVT_W-1:0] : {EVT_W{1'b0}};

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            event_flags <= '0;
            event_mask  <= MASK_RST;
        end else if (state == PPS_NOSUP) begin
            event_flags <= '0;
            event_mask  <= MASK_RST;
        end else begin
            event_flags <= (event_flags & ~evt_clr) | evt_set;
            if (warm_go) begin
                event_mask <= MASK_RST;
            end else if (apb_wr && a_mask) begin
                event_mask <= PWDATA_IN[EVT_W-1:0];
            end
        end
    end

    // Read data captured in the setup phase so it comes from a flop
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            prdata <= 32'h0;
        end else if (apb_setup) begin
            prdata <= PWRITE_IN ? 32'h0 : rd_mux;
        end
    end

    assign PRDATA_OUT     = prdata;
    assign PREADY_OUT     = 1'b1;
    assign PSLVERR_OUT    = PSEL_IN & PENABLE_IN & ~mapped;
    assign START_THR_OUT  = start_thr;
    assign LOW_THR_OUT    = OTP_LOW;
    assign BUS_DET_EN_OUT = powered;
    assign RESOURCE_OUT   = resource;
    assign STATE_OUT      = state;
    assign SEQ_BUSY_OUT   = seq_busy;
    assign INT_N_OUT      = ~|(event_flags & ~event_mask);

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);

    a_nosup_all_off: assert property (
        !POR_OK_IN |=> state == PPS_NOSUP && resource == RES_RST
                       && !seq_busy)
        else $error("not idle below power-on level");

    a_por_to_backup: assert property (
        state == PPS_NOSUP && POR_OK_IN |=> state == PPS_BACKUP)
        else $error("no-supply did not move to backup");

    a_low_rise_off: assert property (
        state == PPS_BACKUP && POR_OK_IN && LOW_OK_IN |=> state == PPS_OFF)
        else $error("backup did not move to off");

    a_low_fall_back: assert property (
        low_loss |=> state == PPS_BACKUP && event_flags[EVT_LOW])
        else $error("supply loss did not return to backup");

    a_start_gated: assert property (
        state == PPS_OFF && !MON_OK_IN |=> state != PPS_ACTIVE)
        else $error("started with supply monitor low");

    a_warm_default: assert property (
        warm_go && POR_OK_IN && LOW_OK_IN |=>
            start_thr == OTP_START && state == PPS_ACTIVE &&
            resource == RES_RST && seq_busy)
        else $error("warm reset did not restore defaults");

    a_thr_write: assert property (
        apb_wr && a_start && run_up && !warm_go && POR_OK_IN |=>
            START_THR_OUT == $past(PWDATA_IN[THR_W-1:0]))
        else $error("threshold write not applied");

    a_bus_event: assert property (
        bus_cross |=> event_flags[EVT_BUS])
        else $error("bus detector crossing lost");

    a_seq_runs: assert property (
        disable iff (RST_IN || !POR_OK_IN || !LOW_OK_IN)
        seq_go && POR_OK_IN && LOW_OK_IN |=> seq_busy[*8])
        else $error("sequence did not run");

    a_res_write: assert property (
        apb_wr && a_res && !seq_busy && !supply_gone && !seq_go |=>
            resource == $past(PWDATA_IN[RES_W-1:0]))
        else $error("resource write after sequence lost");

    a_int_line: assert property (
        (event_flags & ~event_mask) != '0 |-> !INT_N_OUT)
        else $error("interrupt line not asserted");

    a_int_on_event: assert property (
        (evt_set & ~event_mask) != '0 && !(apb_wr && a_mask) |=>
            !INT_N_OUT)
        else $error("unmasked event did not reach interrupt line");

    a_hold_only_on: assert property (
        HOLD_MODE && state == PPS_OFF && !hold_s && !bus_evt |=>
            state != PPS_ACTIVE)
        else $error("switched on without hold request");

    c_power_up: cover property (
        state == PPS_OFF ##1 state == PPS_ACTIVE ##[1:600] !seq_busy);
    c_sleep_wake: cover property (
        state == PPS_SLEEP ##[1:600] state == PPS_ACTIVE);
    c_warm: cover property (warm_go ##[1:600] !seq_busy);
    c_loss: cover property (state == PPS_ACTIVE ##1 state == PPS_BACKUP);
    c_bus_on: cover property (state == PPS_OFF && bus_evt ##1
        state == PPS_ACTIVE);

endmodule : pps_power_ctrl

`default_nettype wire
